// ==== hw/cfg_pkg.sv ====
// Purpose: shared constants and types for the option byte decoder
// Assumes: 8-bit option bytes, 32-bit Avalon-MM register words
// Notes: byte offsets are word aligned; fields sit in the low byte
package cfg_pkg;
    // register byte offsets
    localparam logic [3:0] ADDR_OPT0 = 4'h0;
    localparam logic [3:0] ADDR_OPT1 = 4'h4;
    localparam logic [3:0] ADDR_CTRL = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hC;
    // control and status bit positions
    localparam int CTRL_ERASE = 0;
    localparam int CTRL_CLR_REFUSED = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PROG = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_ROM = 3;
    localparam int STAT_LOADED = 4;
    // option byte 0 fields
    localparam int B0_HALT = 7;
    localparam int B0_WDG = 6;
    localparam int B0_VD_HI = 5;
    localparam int B0_VD_LO = 4;
    localparam int B0_SEC_HI = 3;
    localparam int B0_SEC_LO = 2;
    localparam int B0_RDP = 1;
    localparam int B0_WRP = 0;
    // option byte 1 fields
    localparam int B1_PORTC = 7;
    localparam int B1_CSS = 6;
    localparam int B1_OSC_HI = 5;
    localparam int B1_OSC_LO = 4;
    localparam int B1_RNG_HI = 3;
    localparam int B1_RNG_LO = 1;
    localparam int B1_PLL = 0;
    // values
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] DEFAULT_OPT0 = 8'hFC;
    localparam logic [7:0] DEFAULT_OPT1 = 8'hEF;
    localparam logic [12:0] SEC0_BASE_BYTES = 13'h0200;
    localparam logic [1:0] VD_OFF = 2'h3;
    localparam logic [1:0] VD_LOW = 2'h2;
    localparam logic [1:0] VD_MED = 2'h1;
    localparam logic [1:0] VD_HIGH = 2'h0;
    localparam logic [1:0] OSC_RESONATOR = 2'h0;
    localparam logic [1:0] OSC_RSVD = 2'h1;
    localparam logic [1:0] OSC_RC = 2'h2;
    localparam logic [1:0] OSC_EXT = 2'h3;

    typedef enum logic [1:0] {
        DET_LOW = 2'h0,
        DET_MED = 2'h1,
        DET_HIGH = 2'h2,
        DET_NONE = 2'h3
    } det_level_e;

    typedef enum logic [2:0] {
        RNG_LP = 3'h0,
        RNG_MP = 3'h1,
        RNG_MS = 3'h2,
        RNG_HS = 3'h3,
        RNG_VLP = 3'h4
    } osc_range_e;

    typedef enum logic [1:0] {
        NVM_NONE = 2'h0,
        NVM_PROG = 2'h1,
        NVM_ERASE_OPT = 2'h2,
        NVM_ERASE_MAIN = 2'h3
    } nvm_cmd_e;

    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_PROG = 2'h1,
        S_WIPE = 2'h2,
        S_ERASE = 2'h3
    } seq_state_e;

    typedef struct packed {
        logic halt_rst_en;
        logic wdg_always_on;
        logic det_on;
        det_level_e det_level;
        logic [12:0] sec0_bytes;
        logic readout_on;
        logic write_lock;
        logic portc_vec_b;
        logic clock_guard_on;
        logic [1:0] osc_kind;
        logic osc_kind_rsvd;
        osc_range_e osc_range;
        logic pll_x2_on;
    } cfg_s;
endpackage

// ==== hw/opt_cfg_if.sv ====
// Purpose: carries captured option bytes and decoded configuration
// Assumes: one clock domain, driven by the loader and the decoder
// Notes: no clocking block; plain wires between two modules
`timescale 1ns/1ps
interface opt_cfg_if;
    logic [7:0] opt0;
    logic [7:0] opt1;
    logic loaded;
    cfg_pkg::cfg_s cfg;
    logic cfg_valid;
    modport src(output opt0, output opt1, output loaded,
                input cfg, input cfg_valid);
    modport dec(input opt0, input opt1, input loaded,
                output cfg, output cfg_valid);
endinterface

// ==== hw/option_byte_config_decoder.sv ====
// Purpose: option byte loader, programming port and config outputs
// Assumes: Avalon-MM port is the programming tool's path only
// Notes: nvm command valid holds until the array pulses done
//
// How it works
// - option bytes reachable only in programming mode
// - erased option bytes read as all ones
// - halt with watchdog running requests reset
// - bit six low keeps watchdog always on
// - two bits pick detector threshold or off
// - two bits give sector zero size
// - readout lock blocks memory outside user/iap
// - erase under readout lock wipes memory first
// - write lock refuses program and erase forever
// - port C interrupts go to vector a/b
// - bit six low enables clock guard
// - rom variant uses fixed bytes, no changes
// - two bits select oscillator kind
// - three bits select oscillator range
// - bit zero low enables frequency doubler
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
module option_byte_config_decoder #(
    parameter bit ROM_VARIANT = 1'b0, // fixed bytes, no programming
    parameter logic [7:0] ROM_OPT0 = cfg_pkg::DEFAULT_OPT0, // rom byte 0
    parameter logic [7:0] ROM_OPT1 = cfg_pkg::DEFAULT_OPT1 // rom byte 1
) (
    input wire logic clk_sys, // 125 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // registered read data
    output logic avs_waitrequest, // low marks the answer
    input wire logic prog_mode, // device in programming mode
    input wire logic user_mode, // cpu runs user code
    input wire logic in_app_programming, // iap mode active
    input wire logic halt_entry, // pulse: cpu enters halt
    input wire logic wdg_running, // watchdog counting
    input wire logic [7:0] nvm_opt0_rd, // array cell, byte 0
    input wire logic [7:0] nvm_opt1_rd, // array cell, byte 1
    output logic nvm_cmd_valid, // command pending
    output cfg_pkg::nvm_cmd_e nvm_cmd, // command kind
    output logic nvm_cmd_sel, // byte select, 1 = byte 1
    output logic [7:0] nvm_cmd_data, // program data
    input wire logic nvm_cmd_done, // pulse: command finished
    output logic halt_wdg_reset, // pulse: reset on halt
    output logic watchdog_hw_enable, // watchdog always on
    output logic low_supply_detector_en, // main detector on
    output logic aux_supply_detector_en, // aux detector on
    output cfg_pkg::det_level_e voltage_detect_level, // threshold
    output logic [12:0] sector0_size, // sector 0 bytes
    output logic pmem_read_block, // program memory read blocked
    output logic pmem_write_block, // program memory writes refused
    output logic portc_irq_map, // 1: port C on vector b
    output logic ext_irq_vector_a_portc, // port C on vector a
    output logic clock_guard_enable, // clock guard active
    output logic [1:0] osc_kind, // clock source kind
    output logic osc_kind_reserved, // reserved kind chosen
    output cfg_pkg::osc_range_e osc_range, // oscillator range
    output logic freq_doubler_on, // x2 multiplier active
    output logic cfg_valid // fields decoded
);
    opt_cfg_if link();

    option_field_decoder u_dec (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .link(link.dec)
    );

    // live view of the option cells
    logic [7:0] src0;
    logic [7:0] src1;
    logic wp_live;
    logic rdp_live;

    // rom parts ignore the array entirely
    always_comb begin
        src0 = ROM_VARIANT ? ROM_OPT0 : nvm_opt0_rd;
        src1 = ROM_VARIANT ? ROM_OPT1 : nvm_opt1_rd;
        wp_live = src0[cfg_pkg::B0_WRP];
        rdp_live = src0[cfg_pkg::B0_RDP];
    end

    // capture group
    logic loaded_reg;
    logic loaded_next;
    logic [7:0] cap0_reg;
    logic [7:0] cap0_next;
    logic [7:0] cap1_reg;
    logic [7:0] cap1_next;

    // take the bytes at the first edge after release, then freeze
    always_comb begin
        loaded_next = 1'b1;
        cap0_next = loaded_reg ? cap0_reg : src0;
        cap1_next = loaded_reg ? cap1_reg : src1;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            loaded_reg <= 1'b0;
            cap0_reg <= cfg_pkg::ERASED_BYTE;
            cap1_reg <= cfg_pkg::ERASED_BYTE;
        end else begin
            loaded_reg <= loaded_next;
            cap0_reg <= cap0_next;
            cap1_reg <= cap1_next;
        end
    end

    assign link.opt0 = cap0_reg;
    assign link.opt1 = cap1_reg;
    assign link.loaded = loaded_reg;

    // bus group
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic req;
    logic hit_opt;
    logic hit_ctrl;
    logic seq_wr;
    logic wr_do;
    cfg_pkg::seq_state_e state_reg;
    cfg_pkg::seq_state_e state_next;
    logic refused_reg;
    logic refused_next;

    // writes that start a command wait while one is in flight
    always_comb begin
        hit_opt = avs_byteenable[0] &&
            (avs_address == cfg_pkg::ADDR_OPT0 ||
             avs_address == cfg_pkg::ADDR_OPT1);
        hit_ctrl = avs_byteenable[0] &&
            (avs_address == cfg_pkg::ADDR_CTRL);
        seq_wr = avs_write && (hit_opt ||
            (hit_ctrl && avs_writedata[cfg_pkg::CTRL_ERASE]));
        req = (avs_read || avs_write) && !ack_reg;
        ack_next = req && !(seq_wr && state_reg != cfg_pkg::S_IDLE);
        rdata_next = rdata_reg;
        if (ack_next && avs_read) begin
            rdata_next = 32'h0000_0000; // unmapped reads zero
            case (avs_address)
                cfg_pkg::ADDR_OPT0:
                    if (prog_mode)
                        rdata_next[7:0] = src0;
                cfg_pkg::ADDR_OPT1:
                    if (prog_mode)
                        rdata_next[7:0] = src1;
                cfg_pkg::ADDR_STAT: begin
                    rdata_next[cfg_pkg::STAT_BUSY] =
                        (state_reg != cfg_pkg::S_IDLE);
                    rdata_next[cfg_pkg::STAT_PROG] = prog_mode;
                    rdata_next[cfg_pkg::STAT_REFUSED] = refused_reg;
                    rdata_next[cfg_pkg::STAT_ROM] = ROM_VARIANT;
                    rdata_next[cfg_pkg::STAT_LOADED] = loaded_reg;
                end
                default: ;
            endcase
        end
        wr_do = ack_reg && avs_write; // effect at the answering edge
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest = !ack_reg;
    assign avs_readdata = rdata_reg;

    // command sequencer group
    cfg_pkg::nvm_cmd_e cmd_reg;
    cfg_pkg::nvm_cmd_e cmd_next;
    logic sel_reg;
    logic sel_next;
    logic [7:0] data_reg;
    logic [7:0] data_next;
    logic blocked;
    logic refuse;

    // program/erase of option cells, with lock and wipe ordering
    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        sel_next = sel_reg;
        data_next = data_reg;
        refuse = 1'b0;
        blocked = !prog_mode || ROM_VARIANT;
        case (state_reg)
            cfg_pkg::S_IDLE: begin
                if (wr_do && hit_opt) begin
                    if (blocked || wp_live) begin
                        refuse = 1'b1;
                    end else begin
                        state_next = cfg_pkg::S_PROG;
                        cmd_next = cfg_pkg::NVM_PROG;
                        sel_next = (avs_address == cfg_pkg::ADDR_OPT1);
                        data_next = avs_writedata[7:0];
                    end
                end else if (wr_do && hit_ctrl &&
                             avs_writedata[cfg_pkg::CTRL_ERASE]) begin
                    if (blocked || wp_live) begin
                        refuse = 1'b1;
                    end else if (rdp_live) begin
                        state_next = cfg_pkg::S_WIPE;
                        cmd_next = cfg_pkg::NVM_ERASE_MAIN;
                    end else begin
                        state_next = cfg_pkg::S_ERASE;
                        cmd_next = cfg_pkg::NVM_ERASE_OPT;
                    end
                end
            end
            cfg_pkg::S_PROG:
                if (nvm_cmd_done) begin
                    state_next = cfg_pkg::S_IDLE;
                    cmd_next = cfg_pkg::NVM_NONE;
                end
            cfg_pkg::S_WIPE:
                if (nvm_cmd_done) begin
                    state_next = cfg_pkg::S_ERASE;
                    cmd_next = cfg_pkg::NVM_ERASE_OPT;
                end
            cfg_pkg::S_ERASE:
                if (nvm_cmd_done) begin
                    state_next = cfg_pkg::S_IDLE;
                    cmd_next = cfg_pkg::NVM_NONE;
                end
            default: begin
                state_next = cfg_pkg::S_IDLE;
                cmd_next = cfg_pkg::NVM_NONE;
            end
        endcase
        // sticky refusal; a new refusal beats the clear
        refused_next = refused_reg;
        if (wr_do && hit_ctrl &&
            avs_writedata[cfg_pkg::CTRL_CLR_REFUSED])
            refused_next = 1'b0;
        if (refuse)
            refused_next = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= cfg_pkg::S_IDLE;
            cmd_reg <= cfg_pkg::NVM_NONE;
            sel_reg <= 1'b0;
            data_reg <= cfg_pkg::ERASED_BYTE;
            refused_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            sel_reg <= sel_next;
            data_reg <= data_next;
            refused_reg <= refused_next;
        end
    end

    assign nvm_cmd_valid = (state_reg != cfg_pkg::S_IDLE);
    assign nvm_cmd = cmd_reg;
    assign nvm_cmd_sel = sel_reg;
    assign nvm_cmd_data = data_reg;

    // runtime gating group
    logic halt_rst_reg;
    logic halt_rst_next;
    logic rd_block_reg;
    logic rd_block_next;

    // registered so the gates never glitch on mode changes
    always_comb begin
        halt_rst_next = halt_entry && wdg_running &&
            link.cfg.halt_rst_en;
        rd_block_next = link.cfg.readout_on &&
            !(user_mode || in_app_programming);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            halt_rst_reg <= 1'b0;
            rd_block_reg <= 1'b1; // locked until config known
        end else begin
            halt_rst_reg <= halt_rst_next;
            rd_block_reg <= rd_block_next;
        end
    end

    // halt reset and read block from the gating flops, other decoded fields straight from the decoder's flops
    assign halt_wdg_reset = halt_rst_reg;
    assign pmem_read_block = rd_block_reg;
    assign pmem_write_block = link.cfg.write_lock;
    assign watchdog_hw_enable = link.cfg.wdg_always_on;
    assign low_supply_detector_en = link.cfg.det_on;
    assign aux_supply_detector_en = link.cfg.det_on;
    assign voltage_detect_level = link.cfg.det_level;
    assign sector0_size = link.cfg.sec0_bytes;
    assign portc_irq_map = link.cfg.portc_vec_b;
    assign ext_irq_vector_a_portc = !link.cfg.portc_vec_b;
    assign clock_guard_enable = link.cfg.clock_guard_on;
    assign osc_kind = link.cfg.osc_kind;
    assign osc_kind_reserved = link.cfg.osc_kind_rsvd;
    assign osc_range = link.cfg.osc_range;
    assign freq_doubler_on = link.cfg.pll_x2_on;
    assign cfg_valid = link.cfg_valid;
endmodule

// ==== hw/option_field_decoder.sv ====
// Purpose: turns the two captured option bytes into config fields
// Assumes: bytes stay constant once loaded is high
// Notes: outputs registered; reset shows the erased-byte decoding
`timescale 1ns/1ps
module option_field_decoder (
    input wire logic clk_sys, // system clock
    input wire logic nrst, // async reset, active low
    opt_cfg_if.dec link // captured bytes in, fields out
);
    // field decode of both bytes
    function automatic cfg_pkg::cfg_s decode(input logic [7:0] b0,
                                             input logic [7:0] b1);
        cfg_pkg::cfg_s c;
        logic [1:0] vd;
        logic [2:0] rng;
        vd = b0[cfg_pkg::B0_VD_HI:cfg_pkg::B0_VD_LO];
        rng = b1[cfg_pkg::B1_RNG_HI:cfg_pkg::B1_RNG_LO];
        c.halt_rst_en = b0[cfg_pkg::B0_HALT];
        c.wdg_always_on = ~b0[cfg_pkg::B0_WDG];
        c.det_on = (vd != cfg_pkg::VD_OFF);
        case (vd)
            cfg_pkg::VD_LOW: c.det_level = cfg_pkg::DET_LOW;
            cfg_pkg::VD_MED: c.det_level = cfg_pkg::DET_MED;
            cfg_pkg::VD_HIGH: c.det_level = cfg_pkg::DET_HIGH;
            default: c.det_level = cfg_pkg::DET_NONE;
        endcase
        c.sec0_bytes = cfg_pkg::SEC0_BASE_BYTES
            << b0[cfg_pkg::B0_SEC_HI:cfg_pkg::B0_SEC_LO];
        c.readout_on = b0[cfg_pkg::B0_RDP];
        c.write_lock = b0[cfg_pkg::B0_WRP];
        c.portc_vec_b = b1[cfg_pkg::B1_PORTC];
        c.clock_guard_on = ~b1[cfg_pkg::B1_CSS];
        c.osc_kind = b1[cfg_pkg::B1_OSC_HI:cfg_pkg::B1_OSC_LO];
        c.osc_kind_rsvd = (c.osc_kind == cfg_pkg::OSC_RSVD);
        case (rng)
            3'h0: c.osc_range = cfg_pkg::RNG_LP;
            3'h1: c.osc_range = cfg_pkg::RNG_MP;
            3'h2: c.osc_range = cfg_pkg::RNG_MS;
            3'h3: c.osc_range = cfg_pkg::RNG_HS;
            default: c.osc_range = cfg_pkg::RNG_VLP;
        endcase
        c.pll_x2_on = ~b1[cfg_pkg::B1_PLL];
        return c;
    endfunction

    localparam cfg_pkg::cfg_s RESET_CFG =
        decode(cfg_pkg::ERASED_BYTE, cfg_pkg::ERASED_BYTE);

    cfg_pkg::cfg_s cfg_reg;
    cfg_pkg::cfg_s cfg_next;
    logic valid_reg;
    logic valid_next;

    // decode every cycle; inputs freeze after capture
    always_comb begin
        cfg_next = decode(link.opt0, link.opt1);
        valid_next = link.loaded;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= RESET_CFG;
            valid_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            valid_reg <= valid_next;
        end
    end

    assign link.cfg = cfg_reg;
    assign link.cfg_valid = valid_reg;
endmodule

// ==== sim/nvm_array_model.sv ====
// Purpose: option byte cells as the array would hold them
// Assumes: one command at a time, done lat+1 cycles after valid
// Notes: bench may overwrite the cells between commands
`timescale 1ns/1ps
module nvm_array_model (
    input wire logic clk_sys, // clock
    input wire logic nvm_cmd_valid, // command pending
    input wire cfg_pkg::nvm_cmd_e nvm_cmd, // command kind
    input wire logic nvm_cmd_sel, // byte select
    input wire logic [7:0] nvm_cmd_data, // program data
    input wire logic [7:0] lat, // counted cycles before done
    output logic nvm_cmd_done, // done pulse
    output logic [7:0] cell0, // byte 0 cell
    output logic [7:0] cell1 // byte 1 cell
);
    logic [7:0] cnt;
    logic [7:0] log_reg; // last commands, newest low
    // blank cells read as all ones
    initial begin
        cell0 = 8'hFF;
        cell1 = 8'hFF;
        cnt = 8'h00;
        nvm_cmd_done = 1'b0;
    end
    // count, then apply and pulse; skip the done cycle itself
    always @(posedge clk_sys) begin
        nvm_cmd_done <= 1'b0;
        if (nvm_cmd_valid && !nvm_cmd_done) begin
            if (cnt >= lat) begin
                cnt <= 8'h00;
                nvm_cmd_done <= 1'b1;
                log_reg <= {log_reg[5:0], nvm_cmd};
                if (nvm_cmd == cfg_pkg::NVM_PROG && nvm_cmd_sel)
                    cell1 <= nvm_cmd_data;
                else if (nvm_cmd == cfg_pkg::NVM_PROG)
                    cell0 <= nvm_cmd_data;
                if (nvm_cmd == cfg_pkg::NVM_ERASE_OPT) begin
                    cell0 <= 8'hFF;
                    cell1 <= 8'hFF;
                end
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// ==== sim/opt_cfg_properties.sv ====
// Purpose: port assertions for the option byte decoder
// Assumes: one clock, async active low reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
module opt_cfg_checker (
    input wire logic clk_sys, // clock
    input wire logic nrst, // reset, active low
    input wire logic halt_entry, // halt pulse
    input wire logic wdg_running, // watchdog counting
    input wire logic halt_wdg_reset, // reset pulse
    input wire logic user_mode, // user mode
    input wire logic in_app_programming, // iap mode
    input wire logic pmem_read_block, // read block
    input wire logic [7:0] nvm_opt0_rd, // live byte 0
    input wire logic nvm_cmd_valid, // command pending
    input wire cfg_pkg::nvm_cmd_e nvm_cmd, // command kind
    input wire logic nvm_cmd_done, // command done
    input wire logic low_supply_detector_en, // detector on
    input wire cfg_pkg::det_level_e voltage_detect_level, // level
    input wire logic [12:0] sector0_size, // sector bytes
    input wire logic portc_irq_map, // vector b
    input wire logic ext_irq_vector_a_portc, // vector a
    input wire logic [1:0] osc_kind, // clock source
    input wire logic osc_kind_reserved, // reserved kind
    input wire logic cfg_valid // fields decoded
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // reset on halt needs both a halt and a running watchdog
    a_halt_cause: assert property (halt_wdg_reset |->
        $past(halt_entry && wdg_running)) else $error("halt reset no cause");
    a_det_code: assert property (cfg_valid |-> low_supply_detector_en ==
        (voltage_detect_level != cfg_pkg::DET_NONE)) else $error("det");
    a_irq_route: assert property (cfg_valid |->
        portc_irq_map != ext_irq_vector_a_portc) else $error("route");
    a_sec_size: assert property (cfg_valid |-> sector0_size inside
        {13'h0200, 13'h0400, 13'h0800, 13'h1000}) else $error("size");
    a_osc_rsvd: assert property (cfg_valid |->
        osc_kind_reserved == (osc_kind == 2'h1)) else $error("kind");
    // decoded fields may not follow live cell changes
    a_cfg_frozen: assert property (cfg_valid && $past(cfg_valid) |->
        $stable({sector0_size, osc_kind, voltage_detect_level,
        portc_irq_map})) else $error("fields moved");
    a_read_open: assert property (cfg_valid &&
        $past(user_mode || in_app_programming) |-> !pmem_read_block)
        else $error("read blocked in user mode");
    a_lock_cmd: assert property ($rose(nvm_cmd_valid) |->
        !$past(nvm_opt0_rd[0])) else $error("command under lock");
    a_wipe_first: assert property ($rose(nvm_cmd_valid) &&
        $past(nvm_opt0_rd[1]) |-> nvm_cmd != cfg_pkg::NVM_ERASE_OPT)
        else $error("option erase before wipe");
    a_erase_next: assert property (nvm_cmd_valid && nvm_cmd_done &&
        nvm_cmd == cfg_pkg::NVM_ERASE_MAIN |=> nvm_cmd_valid &&
        nvm_cmd == cfg_pkg::NVM_ERASE_OPT) else $error("no opt erase");
endmodule

bind option_byte_config_decoder opt_cfg_checker i_chk (.*);

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the option byte decoder
// Assumes: programming tool path is the Avalon port
// Notes: decode table first, bus cases after
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic prog_mode, user_mode, in_app_programming, halt_entry;
    logic wdg_running, nvm_cmd_valid, nvm_cmd_sel, nvm_cmd_done;
    logic [7:0] cell0, cell1, lat, nvm_cmd_data;
    cfg_pkg::nvm_cmd_e nvm_cmd;
    cfg_pkg::det_level_e voltage_detect_level;
    cfg_pkg::osc_range_e osc_range;
    logic halt_wdg_reset, watchdog_hw_enable, low_supply_detector_en;
    logic aux_supply_detector_en, pmem_read_block, pmem_write_block;
    logic portc_irq_map, ext_irq_vector_a_portc, clock_guard_enable;
    logic osc_kind_reserved, freq_doubler_on, cfg_valid;
    logic [1:0] osc_kind;
    logic [12:0] sector0_size;
    int failures, n_checks;
    // byte 0 then byte 1; every decoded value of every field appears
    logic [15:0] rows [5] = '{16'hFCEF, 16'h2002, 16'h9454, 16'h48A7,
        16'h8330};

    option_byte_config_decoder i_dut (.*, .avs_byteenable(4'hF),
        .nvm_opt0_rd(cell0), .nvm_opt1_rd(cell1));
    nvm_array_model i_nvm (.*);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // decoded outputs except halt_wdg_reset and pmem_read_block in one word, cfg_valid lowest
    function logic [29:0] dec();
        return {watchdog_hw_enable, low_supply_detector_en,
            aux_supply_detector_en, voltage_detect_level, sector0_size,
            pmem_write_block, portc_irq_map, ext_irq_vector_a_portc,
            clock_guard_enable, osc_kind, osc_kind_reserved, osc_range,
            freq_doubler_on, cfg_valid};
    endfunction
    // 2 - code maps 10,01,00,11 onto 0,1,2,3
    function logic [29:0] exp_f(input logic [7:0] a, input logic [7:0] b);
        return {~a[6], a[5:4] != 2'h3, a[5:4] != 2'h3, 2'h2 - a[5:4],
            13'h0200 << a[3:2], a[0], b[7], ~b[7], ~b[6], b[5:4],
            b[5:4] == 2'h1, (b[3] ? 3'h4 : {1'b0, b[2:1]}), ~b[0], 1'b1};
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task tmo;
        failures++;
        $display("unexpected at %0t: wait ran out", $time);
        wrap_up();
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // held until a rising edge samples waitrequest low, released after
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
        do begin
            @(posedge clk_sys);
            if (++n > 200) tmo();
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
        tick(1);
    endtask
    // bounded wait: c=1 watches cfg_valid, c=0 nvm_cmd_valid
    task wait_lvl(input bit c, input logic v);
        for (int n = 0; (c ? cfg_valid : nvm_cmd_valid) !== v; n++) begin
            if (n > 200) tmo();
            tick(1);
        end
    endtask
    // outputs show the blank decode while reset is held
    task do_reset;
        nrst <= 1'b0;
        tick(12);
        check(dec(), exp_f(8'hFF, 8'hFF) & ~30'h1);
        check(pmem_read_block, 1'b1);
        nrst <= 1'b1;
        wait_lvl(1'b1, 1'b1);
    endtask

    initial begin
        {avs_read, avs_write, prog_mode, in_app_programming} = 4'h0;
        {halt_entry, wdg_running, user_mode, nrst} = 4'h2;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        lat = 8'h00;
        failures = 0;
        n_checks = 0;
        tick(1);
        foreach (rows[i]) begin
            i_nvm.cell0 <= rows[i][15:8];
            i_nvm.cell1 <= rows[i][7:0];
            do_reset();
            check(dec(), exp_f(rows[i][15:8], rows[i][7:0]));
            i_nvm.cell0 <= ~rows[i][15:8];
            i_nvm.cell1 <= ~rows[i][7:0];
            {halt_entry, wdg_running, user_mode} <= 3'h6;
            tick(1);
            halt_entry <= 1'b0;
            @(negedge clk_sys);
            check(halt_wdg_reset, rows[i][15]);
            check(pmem_read_block, rows[i][9]);
            tick(3);
            user_mode <= 1'b1;
            check(dec(), exp_f(rows[i][15:8], rows[i][7:0]));
        end
        // outside programming mode the bytes are out of reach
        i_nvm.cell0 <= 8'hFC;
        i_nvm.cell1 <= 8'hEF;
        bus(1'b1, cfg_pkg::ADDR_OPT0, 32'h0);
        bus(1'b0, cfg_pkg::ADDR_OPT0, 32'h0);
        check(q, 32'h0);
        bus(1'b0, cfg_pkg::ADDR_STAT, 32'h0);
        check(q, 32'h14);
        bus(1'b1, cfg_pkg::ADDR_CTRL, 32'h2);
        // slow array: program byte 1, then read it back
        prog_mode <= 1'b1;
        lat <= 8'h06;
        bus(1'b1, cfg_pkg::ADDR_OPT1, 32'h5A);
        wait_lvl(1'b0, 1'b0);
        bus(1'b0, cfg_pkg::ADDR_OPT1, 32'h0);
        check(q, 32'h5A);
        // erase under readout lock wipes memory before the bytes
        i_nvm.cell0 <= 8'h02;
        lat <= 8'h00;
        bus(1'b1, cfg_pkg::ADDR_CTRL, 32'h1);
        wait_lvl(1'b0, 1'b0);
        check(i_nvm.log_reg[3:0], 4'hE);
        check({cell0, cell1}, 16'hFFFF);
        // write lock refuses both program and erase
        i_nvm.cell0 <= 8'h01;
        bus(1'b1, cfg_pkg::ADDR_OPT0, 32'h0);
        bus(1'b1, cfg_pkg::ADDR_CTRL, 32'h1);
        check({nvm_cmd_valid, cell0}, 9'h001);
        bus(1'b0, cfg_pkg::ADDR_STAT, 32'h0);
        check(q, 32'h16);
        bus(1'b0, 4'h2, 32'h0);
        check(q, 32'h0);
        wrap_up();
    end
endmodule
